// ===== agcr_agp_master.sv
// Purpose: Behavioural AGP graphics master facing the register pair
// Assumes: Pins change one ns after a rising clk_sys edge
// Notes:   Each task returns aligned one ns after a rising edge
`timescale 1ns/10ps
module agcr_agp_master #(
	parameter logic [2:0] RATE_CAP = 3'h2
) (
	input  wire logic clk_sys,
	output logic      pipeReq_n,
	output logic      sbaFramePin,
	output logic      syncReqPin,
	output logic      opDone
);
	// Idle pin levels from time zero
	initial begin
		pipeReq_n   = 1'b1;
		sbaFramePin = 1'b0;
		syncReqPin  = 1'b0;
		opDone      = 1'b0;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// Two low cycles so the synchroniser cannot miss it
	task automatic pipeOp();
		pipeReq_n = 1'b0;
		step(2);
		pipeReq_n = 1'b1;
	endtask

	task automatic sbaOp(input int len);
		sbaFramePin = 1'b1;
		step(len);
		sbaFramePin = 1'b0;
	endtask

	task automatic syncOp();
		syncReqPin = 1'b1;
		step(2);
		syncReqPin = 1'b0;
	endtask

	// Core reports n finished operations, one per cycle, pulse held
	task automatic doneOp(input int n);
		opDone = 1'b1;
		step(n);
		opDone = 1'b0;
	endtask
endmodule // agcr_agp_master

// ===== agcr_cmd_regs.sv
// Summary of operation
// - Status bits 31:24 read 1Fh, up to 32 queued requests.
// - Status bit 9 reads one: sideband addressing supported.
// - Status bit 5 reports no addressing above 4 GB.
// - Status bit 4 reads one: fast writes supported.
// - Status rate bits 2:0 read 111 for 1X, 2X, 4X.
// - Chosen rate drives main bus and sideband bus alike.
// - Command bit 9 set turns sideband addressing on.
// - Command bit 8 clear: all AGP operations, sync too, ignored.
// - Operations taken while enabled still complete after disable.
// - Sideband command begun enabled still issues if enable drops.
// - Pipelined requests need enable; sideband needs sideband enable too.
// - High-address enable bit 5 has no effect; always off.
// - Command bit 4 gates fast writes, reset clear.
// - One-hot command bits 2:0 select 1X, 2X or 4X.
//
// Purpose: AGP capability status and operating command registers
// Assumes: Configuration accesses are synchronous to clk_sys
// Notes:   Pin inputs pass two flip-flops before use
//          Read data and its valid pulse appear one cycle after the strobe
//          Unmapped reads return zero with a valid pulse, never an error
//          Writes land one cycle after the strobe; mode outputs one more
//          Byte enables pick lanes; only bits 9, 8, 4 and 2:0 can change
//          A read and a write in one cycle return the old command value
//          Pin edges act three edges late: two sync stages, one detector
//          Accept pulses leave the gate flops on that third edge, no later
//          The rate field is stored as written; one-hot is software's duty
//          High-address control is tied off; the target stays below 4 GB
//          The open count is not saturated; the master keeps 32 or fewer
//          Clearing the enable never drops an operation already taken
`timescale 1ns/10ps
`include "agcr_regs.svh"
module agcr_cmd_regs (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic [7:0]  cfgAddr,
	input  wire logic        cfgRead,
	input  wire logic        cfgWrite,
	input  wire logic [3:0]  cfgByteEn,
	input  wire logic [31:0] cfgWdata,
	output logic      [31:0] cfgRdata,
	output logic             cfgRdValid,
	input  wire logic        pipeReq_n,
	input  wire logic        sbaFramePin,
	input  wire logic        syncReqPin,
	input  wire logic        opDone,
	output logic             opAccept,
	output logic             opSideband,
	output logic             syncAck,
	output logic      [5:0]  outstanding,
	output logic      [2:0]  adRate,
	output logic      [2:0]  sbaRate,
	output logic             sbaActive,
	output logic             fastWriteEn,
	output logic             highAddrEn
);
	logic [31:0] command, next_command;
	logic [31:0] next_cfgRdata;
	logic        next_cfgRdValid;
	logic [31:0] statusWord;
	logic [31:0] byteMask;
	logic [2:0]  pinMeta, pinSync;
	logic [2:0]  next_adRate;
	logic        next_sbaActive, next_fastWriteEn;

	agcr_gate_if gif ();

	// Capability word is fixed by construction
	assign statusWord = `AGCR_STATUS_RESET;

	// Byte lanes of a configuration write
	genvar b;
	generate
		for (b = 0; b < 4; b++) begin : g_lane
			assign byteMask[8*b+7:8*b] = {8{cfgByteEn[b]}};
		end
	endgenerate

	// Register next values and read data
	always_comb begin
		next_command = command;
		if (cfgWrite && cfgAddr == `AGCR_OFS_COMMAND)
			next_command = (command & ~(byteMask & `AGCR_COMMAND_WMASK))
				| (cfgWdata & byteMask & `AGCR_COMMAND_WMASK);
		next_cfgRdata = 32'h00000000;
		if (cfgRead) begin
			case (cfgAddr)
				`AGCR_OFS_STATUS:  next_cfgRdata = statusWord;
				`AGCR_OFS_COMMAND: next_cfgRdata = command;
				default:           next_cfgRdata = 32'h00000000;
			endcase
		end
		next_cfgRdValid = cfgRead;
	end

	// Register file
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			command    <= `AGCR_COMMAND_RESET;
			cfgRdata   <= 32'h00000000;
			cfgRdValid <= 1'b0;
		end else begin
			command    <= next_command;
			cfgRdata   <= next_cfgRdata;
			cfgRdValid <= next_cfgRdValid;
		end
	end

	// Two-stage synchroniser for the master's pins
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pinMeta <= 3'h0;
			pinSync <= 3'h0;
		end else begin
			pinMeta <= {syncReqPin, sbaFramePin, ~pipeReq_n};
			pinSync <= pinMeta;
		end
	end

	// Controls to the gate
	assign gif.agpEnable = command[`AGCR_FLD_ENABLE];
	assign gif.sbaEnable = command[`AGCR_FLD_SBA];
	assign gif.pipeSeen  = pinSync[0];
	assign gif.sbaFrame  = pinSync[1];
	assign gif.syncSeen  = pinSync[2];
	assign gif.opDone    = opDone;

	agcr_op_gate agcr_op_gate_i (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.gif     (gif.gate)
	);

	assign opAccept    = gif.accept;
	assign opSideband  = gif.acceptSb;
	assign syncAck     = gif.syncAck;
	assign outstanding = gif.outstanding;

	// Operating mode outputs, one cycle behind the command register
	always_comb begin
		next_adRate      = command[`AGCR_FLD_RATE_MSB:0];
		next_sbaActive   = command[`AGCR_FLD_SBA];
		next_fastWriteEn = command[`AGCR_FLD_FASTWR];
	end

	// Same rate flop image feeds both buses so they never disagree
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			adRate      <= 3'h0;
			sbaRate     <= 3'h0;
			sbaActive   <= 1'b0;
			fastWriteEn <= 1'b0;
			highAddrEn  <= 1'b0;
		end else begin
			adRate      <= next_adRate;
			sbaRate     <= next_adRate;
			sbaActive   <= next_sbaActive;
			fastWriteEn <= next_fastWriteEn;
			highAddrEn  <= 1'b0;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// Status reads and command writes, checked against the constants
	sequence s_statusRead;
		cfgRead && cfgAddr == `AGCR_OFS_STATUS;
	endsequence
	sequence s_cmdWriteAll;
		cfgWrite && cfgAddr == `AGCR_OFS_COMMAND && cfgByteEn == 4'hF;
	endsequence

	a_status_depth: assert property (
		s_statusRead |=> cfgRdata[31:24] == `AGCR_REQ_DEPTH_CODE)
		else $error("status depth field wrong");
	a_status_caps: assert property (
		s_statusRead |=> cfgRdata[`AGCR_FLD_SBA] && cfgRdValid)
		else $error("sideband capability not reported");
	a_status_hiaddr: assert property (
		s_statusRead |=> !cfgRdata[`AGCR_FLD_HIADDR])
		else $error("high address capability reported");
	a_status_fastwr: assert property (
		s_statusRead |=> cfgRdata[`AGCR_FLD_FASTWR])
		else $error("fast write capability missing");
	a_status_rates: assert property (
		s_statusRead |=> cfgRdata[2:0] == `AGCR_RATE_ALL)
		else $error("rate capability not 111");
	a_rate_same: assert property (
		adRate == sbaRate)
		else $error("bus rates differ");
	a_sba_enable: assert property (
		s_cmdWriteAll ##0 cfgWdata[`AGCR_FLD_SBA] |=> ##1 sbaActive)
		else $error("sideband not enabled after write");
	a_disabled_quiet: assert property (
		!command[`AGCR_FLD_ENABLE] [*3] |=> !syncAck && !(opAccept
			&& !opSideband))
		else $error("operation taken while disabled");
	a_complete_after: assert property (
		opDone && outstanding != 6'h00 |=> outstanding
			== $past(outstanding) - 6'h01 || opAccept)
		else $error("open operation not retired");
	a_sb_dropped: assert property (
		gif.sbaFrame && !$past(gif.sbaFrame) && !command[`AGCR_FLD_SBA]
			|=> agcr_op_gate_i.sbState == agcr_pkg::AGCR_SB_DROP)
		else $error("sideband taken without sideband enable");
	a_hiaddr_off: assert property (
		s_cmdWriteAll ##0 cfgWdata[`AGCR_FLD_HIADDR] |=> ##1 !highAddrEn)
		else $error("high address enabled");
	a_fastwr_follow: assert property (
		s_cmdWriteAll |=> ##1 fastWriteEn == $past(cfgWdata[4], 2))
		else $error("fast write enable mismatch");
	a_rate_follow: assert property (
		s_cmdWriteAll |=> ##1 adRate == $past(cfgWdata[2:0], 2))
		else $error("rate select mismatch");
	a_reserved_zero: assert property (
		cfgRead && cfgAddr == `AGCR_OFS_COMMAND |=>
			(cfgRdata & ~`AGCR_COMMAND_WMASK) == 32'h00000000)
		else $error("reserved command bits nonzero");

	// Pin edges as the gate sees them, after the synchroniser
	sequence s_pipeRise;
		gif.pipeSeen && !$past(gif.pipeSeen);
	endsequence
	sequence s_syncRise;
		gif.syncSeen && !$past(gif.syncSeen);
	endsequence
	sequence s_frameRise;
		gif.sbaFrame && !$past(gif.sbaFrame);
	endsequence
	sequence s_frameFall;
		!gif.sbaFrame && $past(gif.sbaFrame);
	endsequence

	// Pipelined requests: taken only while enabled
	a_pipe_taken: assert property (
		s_pipeRise ##0 command[`AGCR_FLD_ENABLE] |=> opAccept)
		else $error("pipelined request not taken");
	a_pipe_ignored: assert property (
		s_pipeRise ##0 !command[`AGCR_FLD_ENABLE] |=> !opAccept
			|| opSideband)
		else $error("pipelined request taken while disabled");

	// Sync cycles: answered only while enabled
	a_sync_ack: assert property (
		s_syncRise ##0 command[`AGCR_FLD_ENABLE] |=> syncAck)
		else $error("sync cycle not answered");
	a_sync_quiet: assert property (
		s_syncRise ##0 !command[`AGCR_FLD_ENABLE] |=> !syncAck)
		else $error("sync cycle answered while disabled");

	// Sideband frames: judged at the start, issued at the end
	a_sb_off_drop: assert property (
		s_frameRise ##0 !command[`AGCR_FLD_ENABLE]
			|=> agcr_op_gate_i.sbState == agcr_pkg::AGCR_SB_DROP)
		else $error("sideband frame taken while disabled");
	a_sb_issue: assert property (
		agcr_op_gate_i.sbState == agcr_pkg::AGCR_SB_TAKE
			##0 s_frameFall |=> opAccept && opSideband)
		else $error("accepted sideband command not issued");
	a_sb_refused: assert property (
		agcr_op_gate_i.sbState == agcr_pkg::AGCR_SB_DROP
			##0 s_frameFall |=> !opSideband)
		else $error("refused sideband command issued");
	a_side_with_accept: assert property (
		opSideband |-> opAccept)
		else $error("sideband pulse without accept");

	// Open operations: count moves only with accepts and completions
	a_count_steady: assert property (
		!gif.opDone ##1 !opAccept
			|-> outstanding == $past(outstanding))
		else $error("open count moved without cause");

	// Register side: reserved, unmapped and read-only space stays inert
	a_unmapped_zero: assert property (
		cfgRead && cfgAddr != `AGCR_OFS_STATUS
			&& cfgAddr != `AGCR_OFS_COMMAND
			|=> cfgRdValid && cfgRdata == 32'h00000000)
		else $error("unmapped read returned data");
	a_status_ro: assert property (
		cfgWrite && cfgAddr == `AGCR_OFS_STATUS
			|=> command == $past(command))
		else $error("status write changed the command");
	a_reserved_wr: assert property (
		cfgWrite
			|=> (command & ~`AGCR_COMMAND_WMASK) == 32'h00000000)
		else $error("reserved command bits written");
	a_status_reserved: assert property (
		s_statusRead
			|=> (cfgRdata & ~`AGCR_STATUS_RESET) == 32'h00000000)
		else $error("reserved status bits set");

	// Mode outputs follow the stored command one cycle late
	a_sba_follow: assert property (
		sbaActive == $past(command[`AGCR_FLD_SBA]))
		else $error("sideband active lags the command");
	a_fastwr_track: assert property (
		fastWriteEn == $past(command[`AGCR_FLD_FASTWR]))
		else $error("fast write enable off the command");
	a_rate_track: assert property (
		adRate == $past(command[`AGCR_FLD_RATE_MSB:0]))
		else $error("main bus rate off the command");
	a_rate_both: assert property (
		sbaRate == $past(command[`AGCR_FLD_RATE_MSB:0]))
		else $error("sideband rate off the command");

endmodule // agcr_cmd_regs

// ===== agcr_gate_if.sv
// Purpose: Carrier between the register bank and the operation gate
// Assumes: One clock domain, all inputs already synchronised
// Notes:   Gate results are flip-flop outputs of the gate
`timescale 1ns/10ps
interface agcr_gate_if;
	logic                 agpEnable;
	logic                 sbaEnable;
	logic                 pipeSeen;
	logic                 sbaFrame;
	logic                 syncSeen;
	logic                 opDone;
	logic                 accept;
	logic                 acceptSb;
	logic                 syncAck;
	agcr_pkg::agcr_count_t outstanding;

	modport gate (
		input  agpEnable, sbaEnable, pipeSeen, sbaFrame, syncSeen, opDone,
		output accept, acceptSb, syncAck, outstanding
	);
	modport bank (
		output agpEnable, sbaEnable, pipeSeen, sbaFrame, syncSeen, opDone,
		input  accept, acceptSb, syncAck, outstanding
	);
endinterface // agcr_gate_if

// ===== agcr_op_gate.sv
// Purpose: Decides which AGP operations are taken and tracks open ones
// Assumes: Inputs are synchronous to clk_sys
// Notes:   Sideband commands are judged at their first cycle
`timescale 1ns/10ps
module agcr_op_gate (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	agcr_gate_if.gate gif
);
	agcr_pkg::agcr_sb_state_t sbState, next_sbState;
	agcr_pkg::agcr_count_t    count, next_count;
	logic pipePrev, sbaPrev, syncPrev;
	logic accept, acceptSb, syncAck;
	logic next_accept, next_acceptSb, next_syncAck;
	logic pipeTake, sbIssue, doneTake;

	// Edges of the request levels and the decisions on them
	always_comb begin
		pipeTake = gif.pipeSeen & ~pipePrev & gif.agpEnable;
		sbIssue  = (sbState == agcr_pkg::AGCR_SB_TAKE) & sbaPrev
			& ~gif.sbaFrame;
		doneTake = gif.opDone & (count != 6'h00);
		next_sbState = sbState;
		case (sbState)
			agcr_pkg::AGCR_SB_IDLE: begin
				if (gif.sbaFrame & ~sbaPrev) begin
					if (gif.agpEnable & gif.sbaEnable)
						next_sbState = agcr_pkg::AGCR_SB_TAKE;
					else
						next_sbState = agcr_pkg::AGCR_SB_DROP;
				end
			end
			agcr_pkg::AGCR_SB_TAKE: begin
				// Enable may drop here; the command still issues
				if (~gif.sbaFrame)
					next_sbState = agcr_pkg::AGCR_SB_IDLE;
			end
			agcr_pkg::AGCR_SB_DROP: begin
				if (~gif.sbaFrame)
					next_sbState = agcr_pkg::AGCR_SB_IDLE;
			end
			default: next_sbState = agcr_pkg::AGCR_SB_IDLE;
		endcase
		next_count = agcr_pkg::agcr_count_t'(count
			+ {5'h00, pipeTake} + {5'h00, sbIssue}
			- {5'h00, doneTake});
		next_accept   = pipeTake | sbIssue;
		next_acceptSb = sbIssue;
		next_syncAck  = gif.syncSeen & ~syncPrev & gif.agpEnable;
	end

	// Registers only
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sbState  <= agcr_pkg::AGCR_SB_IDLE;
			count    <= 6'h00;
			pipePrev <= 1'b0;
			sbaPrev  <= 1'b0;
			syncPrev <= 1'b0;
			accept   <= 1'b0;
			acceptSb <= 1'b0;
			syncAck  <= 1'b0;
		end else begin
			sbState  <= next_sbState;
			count    <= next_count;
			pipePrev <= gif.pipeSeen;
			sbaPrev  <= gif.sbaFrame;
			syncPrev <= gif.syncSeen;
			accept   <= next_accept;
			acceptSb <= next_acceptSb;
			syncAck  <= next_syncAck;
		end
	end

	assign gif.accept      = accept;
	assign gif.acceptSb    = acceptSb;
	assign gif.syncAck     = syncAck;
	assign gif.outstanding = count;

endmodule // agcr_op_gate

// ===== agcr_pkg.sv
// Purpose: Types shared by the AGP register pair and its operation gate
// Assumes: Constants live in agcr_regs.svh
// Notes:   Nothing here is imported; users write agcr_pkg::name
package agcr_pkg;

	// One-hot transfer rate as held in the command register
	typedef enum logic [2:0] {
		AGCR_RATE_NONE = 3'h0,
		AGCR_RATE_1X   = 3'h1,
		AGCR_RATE_2X   = 3'h2,
		AGCR_RATE_4X   = 3'h4
	} agcr_rate_t;

	// Sideband command delivery tracking
	typedef enum logic [2:0] {
		AGCR_SB_IDLE = 3'h1,
		AGCR_SB_TAKE = 3'h2,
		AGCR_SB_DROP = 3'h4
	} agcr_sb_state_t;

	typedef logic [5:0] agcr_count_t;

endpackage

// ===== agcr_regs.svh
// Purpose: Offsets, fields, reset values and counts of the AGP register pair
// Assumes: Configuration offsets are byte addresses on an 8-bit bus
// Notes:   Definitions only
`ifndef AGCR_REGS_SVH
`define AGCR_REGS_SVH

`define AGCR_OFS_STATUS       8'hA4
`define AGCR_OFS_COMMAND      8'hA8
`define AGCR_STATUS_RESET     32'h1F000217
`define AGCR_COMMAND_RESET    32'h00000000
`define AGCR_COMMAND_WMASK    32'h00000317
`define AGCR_REQ_DEPTH_CODE   8'h1F
`define AGCR_REQ_DEPTH        6'h20
`define AGCR_FLD_DEPTH_LSB    24
`define AGCR_FLD_SBA          9
`define AGCR_FLD_ENABLE       8
`define AGCR_FLD_HIADDR       5
`define AGCR_FLD_FASTWR       4
`define AGCR_FLD_RATE_MSB     2
`define AGCR_RATE_ALL         3'h7

`endif

// ===== tb_agp_capability_command_regs.sv
// Purpose: Self-checking bench of the AGP status and command registers
// Assumes: Inputs driven one ns after the rising edge
// Notes:   Acceptance watched over a fixed ten-cycle window
`timescale 1ns/10ps
module tb_agp_capability_command_regs;
	logic        clk_sys, rst_n, cfgRead, cfgWrite, opDone;
	logic [7:0]  cfgAddr;
	logic [3:0]  cfgByteEn;
	logic [31:0] cfgWdata, cfgRdata;
	logic        cfgRdValid, pipeReq_n, sbaFramePin, syncReqPin;
	logic        opAccept, opSideband, syncAck;
	logic        sbaActive, fastWriteEn, highAddrEn;
	logic [5:0]  outstanding;
	logic [2:0]  adRate, sbaRate, fl;
	int          miscompares, n_tests;

	agcr_cmd_regs agcr_cmd_regs_i (.clk_sys(clk_sys), .rst_n(rst_n),
		.cfgAddr(cfgAddr), .cfgRead(cfgRead), .cfgWrite(cfgWrite),
		.cfgByteEn(cfgByteEn), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata),
		.cfgRdValid(cfgRdValid), .pipeReq_n(pipeReq_n),
		.sbaFramePin(sbaFramePin), .syncReqPin(syncReqPin), .opDone(opDone),
		.opAccept(opAccept), .opSideband(opSideband), .syncAck(syncAck),
		.outstanding(outstanding), .adRate(adRate), .sbaRate(sbaRate),
		.sbaActive(sbaActive), .fastWriteEn(fastWriteEn),
		.highAddrEn(highAddrEn));
	agcr_agp_master agcr_agp_master_i (.clk_sys(clk_sys),
		.pipeReq_n(pipeReq_n), .sbaFramePin(sbaFramePin),
		.syncReqPin(syncReqPin), .opDone(opDone));

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// One access; a missing valid pulse spoils the returned word
	task automatic cfg(input logic w, input logic [7:0] a,
			input logic [31:0] d, input logic [3:0] be,
			output logic [31:0] q);
		{cfgWrite, cfgRead, cfgAddr, cfgWdata, cfgByteEn} = {w, !w, a, d, be};
		@(posedge clk_sys);
		#1;
		q = (cfgRdValid === !w) ? cfgRdata : 32'hEEEEEEEE;
		{cfgWrite, cfgRead} = 2'h0;
		@(posedge clk_sys);
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		cfg(1'b0, a, 32'h0, 4'h0, q);
		chk(q, e);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] be);
		logic [31:0] q;
		cfg(1'b1, a, d, be, q);
	endtask

	// Collects {accept, sideband, sync} pulses over the window
	task automatic look();
		fl = 3'h0;
		repeat (10) begin
			fl = fl | {opAccept, opSideband, syncAck};
			@(posedge clk_sys);
			#1;
		end
	endtask

	task automatic t_status();
		rd(8'hA4, 32'h1F000217);
		wr(8'hA4, 32'h0, 4'hF);
		rd(8'hA4, 32'h1F000217);
		rd(8'hA8, 32'h0);
		rd(8'hB0, 32'h0);
		chk({fastWriteEn, sbaActive, highAddrEn}, 3'h0);
	endtask

	task automatic t_command();
		wr(8'hA8, 32'hFFFFFFFF, 4'hF);
		rd(8'hA8, 32'h317);
		chk({sbaActive, fastWriteEn, highAddrEn}, 3'h6);
		wr(8'hA8, 32'h0, 4'hE);
		rd(8'hA8, 32'h017);
		for (int i = 0; i < 3; i++) begin
			wr(8'hA8, 32'h1 << i, 4'hF);
			chk({adRate, sbaRate}, {2{3'h1 << i}});
		end
		// Settle on a rate the master says it has
		wr(8'hA8, {29'h0, agcr_agp_master_i.RATE_CAP}, 4'h1);
		chk(adRate, {29'h0, agcr_agp_master_i.RATE_CAP});
	endtask

	task automatic t_disabled();
		wr(8'hA8, 32'h2, 4'hF);
		agcr_agp_master_i.pipeOp();
		look();
		chk(fl, 3'h0);
		agcr_agp_master_i.sbaOp(4);
		look();
		chk(fl, 3'h0);
		agcr_agp_master_i.syncOp();
		look();
		chk({fl, outstanding}, 9'h0);
	endtask

	task automatic t_enabled();
		wr(8'hA8, 32'h102, 4'hF);
		agcr_agp_master_i.pipeOp();
		look();
		chk(fl, 3'h4);
		agcr_agp_master_i.sbaOp(4);
		look();
		chk(fl, 3'h0);
		agcr_agp_master_i.syncOp();
		look();
		chk(fl, 3'h1);
		wr(8'hA8, 32'h302, 4'hF);
		agcr_agp_master_i.sbaOp(4);
		look();
		chk({fl, outstanding}, {3'h6, 6'h2});
	endtask

	// Enable drops mid-frame; frame still issues, then all drain
	task automatic t_late();
		fork
			agcr_agp_master_i.sbaOp(8);
			begin
				repeat (5) @(posedge clk_sys);
				#1;
				wr(8'hA8, 32'h0, 4'hF);
			end
		join
		look();
		chk({fl, outstanding}, {3'h6, 6'h3});
		agcr_agp_master_i.doneOp(3);
		chk(outstanding, 6'h0);
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	initial begin
		#200000;
		miscompares++;
		end_of_test();
	end

	initial begin
		{rst_n, cfgRead, cfgWrite, cfgAddr, cfgByteEn, cfgWdata} = '0;
		miscompares = 0;
		n_tests = 0;
		repeat (4) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		t_status();
		t_command();
		t_disabled();
		t_enabled();
		t_late();
		end_of_test();
	end
endmodule // tb_agp_capability_command_regs
